/* node_pkg.sv */
// Purpose: shared constants, types and helpers of the token ring node controller
// Assumes: 100 MHz core clock, 2.5 Mbps line rate
// Notes:   message kind codes and host addresses are local encodings
package node_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ  = 100;
  localparam int unsigned BIT_NS   = 400;
  localparam int unsigned RESP_NS  = 37400;
  localparam int unsigned GAP_BITS = 20;
  localparam int unsigned BIT_CYC  = (BIT_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned QTR_CYC  = BIT_CYC / 4;
  localparam int unsigned RESP_CYC = RESP_NS * CLK_MHZ / 1000;
  localparam int unsigned GAP_CYC  = GAP_BITS * BIT_CYC;

  // ----------------------------------------------------------------
  // host port map and fields
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_DEST = 3'h1;
  localparam logic [2:0] ADDR_LEN  = 3'h2;
  localparam logic [2:0] ADDR_CMD  = 3'h3;
  localparam logic [2:0] ADDR_MASK = 3'h4;
  localparam logic [2:0] ADDR_NODE = 3'h5;
  localparam logic [2:0] ADDR_NEXT = 3'h6;
  localparam int unsigned CMD_TX     = 0;
  localparam int unsigned CMD_RX_ON  = 1;
  localparam int unsigned CMD_RX_OFF = 2;
  localparam int unsigned CMD_CLR    = 3;
  localparam int unsigned ST_TXAV    = 0;
  localparam int unsigned ST_ACKED   = 1;
  localparam int unsigned ST_RXD     = 2;
  localparam int unsigned ST_ROOM    = 3;
  localparam logic [3:0]  STAT_RST   = 4'h1;

  // ----------------------------------------------------------------
  // line messages
  // ----------------------------------------------------------------
  localparam logic [7:0]  KIND_ITT  = 8'h04;
  localparam logic [7:0]  KIND_ENQ  = 8'h85;
  localparam logic [7:0]  KIND_ACK  = 8'h86;
  localparam logic [7:0]  KIND_NAK  = 8'h15;
  localparam logic [7:0]  KIND_PKT  = 8'h01;
  localparam logic [15:0] CRC_INIT  = 16'h0000;
  localparam logic [15:0] CRC_POLY  = 16'ha001;

  typedef enum logic [1:0] {PH_IDLE, PH_TX, PH_WAIT_ENQ, PH_WAIT_ACK} phase_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] data;
  } host_req_t;

  typedef struct packed {
    logic        wr_prev, oe, irq_n;
    logic [7:0]  rdata, dest, len, mask, node, next_id, rxbyte;
    logic [3:0]  stat;
    logic        tx_pend, rx_en, pol_high;
    logic [15:0] div;
    logic [1:0]  qtr;
    logic        bclk, ser_busy;
    logic [8:0]  ser_sh;
    logic [3:0]  ser_bit;
    logic        pa_n, pa_oe, pb_n, pb_oe, txen;
    phase_t      ph;
    logic [7:0]  kind, tdid;
    logic [8:0]  tidx;
    logic        tlast;
    logic [15:0] tcrc, wcnt;
    logic        rx_busy;
    logic [15:0] rx_cnt;
    logic [3:0]  rx_bit;
    logic [7:0]  rx_sh;
    logic [8:0]  ridx;
    logic [7:0]  rkind, rdid, rlen, rhi;
    logic [15:0] rcrc, rgap;
  } node_st_t;

  localparam node_st_t ST_RST = '{pa_n: 1'b1, pa_oe: 1'b1, pb_n: 1'b1, irq_n: 1'b1, txen: 1'b1,
                                  stat: STAT_RST, ph: PH_IDLE, default: '0};

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction

endpackage

/* pair_buffer.sv */
// Purpose: two-entry valid/ready buffer
// Assumes: single clock, async reset plus synchronous clear
// Notes:   full when two words held, no word lost on a stall
`timescale 1ns/1ps
module pair_buffer #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  input  wire logic             clear_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  typedef struct packed {
    logic [1:0][WIDTH-1:0] slot;
    logic [1:0]            cnt;
  } buf_st_t;

  buf_st_t q, n;

  assign in_ready_out  = (q.cnt != 2'd2);
  assign out_valid_out = (q.cnt != 2'd0);
  assign out_data_out  = q.slot[0];

  always_comb begin
    n = q;
    if (out_valid_out && out_ready_in) begin
      n.slot[0] = q.slot[1];
      n.cnt     = n.cnt - 2'd1;
    end
    if (in_valid_in && in_ready_out) begin
      n.slot[n.cnt[0]] = in_data_in;
      n.cnt            = n.cnt + 2'd1;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q <= '0;
    end else if (clear_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  a_buf_bound: assert property (@(posedge clk_in) disable iff (rst_in) q.cnt != 2'd3)
    else $error("buffer count out of range");
endmodule

/* token_node.sv */
// Purpose: token ring node controller: host port, sequencer, line coder
// Assumes: host and line inputs synchronous to core_clk_in
// Notes:   hw_reset_n_in low clears all state and samples the polarity strap
`timescale 1ns/1ps
module token_node
  import node_pkg::*;
#(
  parameter int unsigned QTR  = QTR_CYC,
  parameter int unsigned BITS = BIT_CYC,
  parameter int unsigned RESP = RESP_CYC,
  parameter int unsigned GAP  = GAP_CYC
) (
  input  wire logic       core_clk_in,
  input  wire logic       sys_rst_in,
  input  wire logic       hw_reset_n_in,
  input  wire logic       chip_select_n_in,
  input  wire logic       read_strobe_or_data_strobe_n_in,
  input  wire logic       write_strobe_or_direction_in,
  input  wire logic       bus_strobe_mode_in,
  input  wire logic [2:0] host_addr_in,
  input  wire logic [7:0] host_data_in,
  output logic [7:0]      host_data_out,
  output logic            host_data_oe_out,
  output logic            host_irq_n_out,
  input  wire logic       backplane_mode_in,
  input  wire logic       pulse_a_open_drain_in,
  output logic            line_pulse_a_n_out,
  output logic            line_pulse_a_oe_out,
  input  wire logic       line_pulse_b_n_in,
  output logic            line_pulse_b_n_out,
  output logic            line_pulse_b_oe_out,
  input  wire logic       line_receive_in,
  output logic            line_driver_enable_out
);
  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  node_st_t  q, n;
  host_req_t req;
  logic       acc_wr, acc_rd, tick, nb_ok, is_data, is_crc, rx_strobe;
  logic       msg_done, crc_ok, addressed, tmo, tx_act, cur;
  logic       buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
  logic [7:0] buf_out_data, nb, rbyte, mk, mdid;
  logic [8:0] last_idx;

  function automatic node_st_t start_tx(node_st_t s, logic [7:0] k, logic [7:0] d);
    node_st_t r;
    r       = s;
    r.ph    = PH_TX;
    r.kind  = k;
    r.tdid  = d;
    r.tidx  = '0;
    r.tlast = 1'b0;
    r.tcrc  = CRC_INIT;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // host access decode
  // ----------------------------------------------------------------
  assign acc_rd = !chip_select_n_in && !read_strobe_or_data_strobe_n_in
                  && write_strobe_or_direction_in;
  assign acc_wr = !chip_select_n_in && !write_strobe_or_direction_in
                  && (!bus_strobe_mode_in || !read_strobe_or_data_strobe_n_in);
  assign req = '{wr: acc_wr && !q.wr_prev, rd: acc_rd, addr: host_addr_in, data: host_data_in};
  assign buf_in_valid = req.wr && (req.addr == ADDR_DATA);

  pair_buffer #(.WIDTH(8)) u_txbuf (
    .clk_in        (core_clk_in),
    .rst_in        (sys_rst_in),
    .clear_in      (!hw_reset_n_in),
    .in_valid_in   (buf_in_valid),
    .in_ready_out  (buf_in_ready),
    .in_data_in    (req.data),
    .out_valid_out (buf_out_valid),
    .out_ready_in  (buf_out_ready),
    .out_data_out  (buf_out_data)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    n             = q;
    buf_out_ready = 1'b0;
    rx_strobe     = 1'b0;
    msg_done      = 1'b0;
    nb            = 8'h00;
    nb_ok         = 1'b1;
    tick          = (q.div == 16'(QTR - 1));
    n.div         = tick ? 16'h0000 : q.div + 16'h0001;
    rbyte         = q.rx_sh;
    mk            = (q.ridx == 9'h000) ? rbyte : q.rkind;
    mdid          = (q.ridx == 9'h001) ? rbyte : q.rdid;
    addressed     = (mk == KIND_ACK) || (mk == KIND_NAK) || (mdid == q.node);
    crc_ok        = ({q.rhi, rbyte} == q.rcrc);
    tmo           = (q.wcnt == 16'(RESP - 1));
    is_data       = (q.kind == KIND_PKT) && (q.tidx >= 9'h003) && (q.tidx <= {1'b0, q.len} + 9'h002);
    is_crc        = (q.kind == KIND_PKT) && (q.tidx >= 9'h001) && (q.tidx <= {1'b0, q.len} + 9'h002);
    // host port
    n.wr_prev = acc_wr;
    n.oe      = req.rd;
    case (req.addr)
      ADDR_DATA: n.rdata = q.rxbyte;
      ADDR_DEST: n.rdata = q.dest;
      ADDR_LEN:  n.rdata = q.len;
      ADDR_CMD:  n.rdata = {4'h0, q.stat};
      ADDR_MASK: n.rdata = q.mask;
      ADDR_NODE: n.rdata = q.node;
      ADDR_NEXT: n.rdata = q.next_id;
      default:   n.rdata = 8'h00;
    endcase
    if (req.wr) begin
      case (req.addr)
        ADDR_DEST: n.dest    = req.data;
        ADDR_LEN:  n.len     = req.data;
        ADDR_MASK: n.mask    = req.data;
        ADDR_NODE: n.node    = req.data;
        ADDR_NEXT: n.next_id = req.data;
        ADDR_CMD: begin
          if (req.data[CMD_TX]) begin
            n.tx_pend       = 1'b1;
            n.stat[ST_TXAV] = 1'b0;
          end
          if (req.data[CMD_RX_ON]) n.rx_en = 1'b1;
          if (req.data[CMD_RX_OFF]) n.rx_en = 1'b0;
          if (req.data[CMD_CLR]) begin
            n.stat[ST_ACKED] = 1'b0;
            n.stat[ST_RXD]   = 1'b0;
          end
        end
        default: n.dest = n.dest;
      endcase
    end
    // receive deserialiser
    if (!q.rx_busy) begin
      if (line_receive_in) begin
        n.rx_busy = 1'b1;
        n.rx_cnt  = 16'h0000;
        n.rx_bit  = 4'h0;
      end
    end else begin
      n.rx_cnt = q.rx_cnt + 16'h0001;
      if ((q.rx_cnt == 16'(QTR / 2)) && (q.rx_bit != 4'h0)) n.rx_sh = {line_receive_in, q.rx_sh[7:1]};
      if (q.rx_cnt == 16'(BITS - 1)) begin
        n.rx_cnt = 16'h0000;
        if (q.rx_bit == 4'h8) begin
          n.rx_busy = 1'b0;
          rx_strobe = 1'b1;
        end else begin
          n.rx_bit = q.rx_bit + 4'h1;
        end
      end
    end
    // message parser, own echo ignored
    if (rx_strobe && (q.ph != PH_TX)) begin
      n.rgap = 16'h0000;
      n.ridx = q.ridx + 9'h001;
      if (q.ridx == 9'h000) n.rkind = rbyte;
      if (q.ridx == 9'h001) n.rdid = rbyte;
      if (q.ridx == 9'h002) n.rlen = rbyte;
      if ((q.ridx == 9'h001) || (q.ridx == 9'h002)) n.rcrc = crc_step(q.rcrc, rbyte);
      if ((q.ridx >= 9'h003) && (q.ridx <= {1'b0, q.rlen} + 9'h002)) begin
        n.rcrc   = crc_step(q.rcrc, rbyte);
        n.rxbyte = rbyte;
      end
      if ((q.ridx >= 9'h003) && (q.ridx == {1'b0, q.rlen} + 9'h003)) n.rhi = rbyte;
      if (q.ridx == 9'h000) begin
        msg_done = (rbyte == KIND_ACK) || (rbyte == KIND_NAK);
        if (!msg_done && (rbyte != KIND_ITT) && (rbyte != KIND_ENQ) && (rbyte != KIND_PKT)) n.ridx = 9'h000;
      end else if (q.ridx == 9'h001) begin
        msg_done = (q.rkind == KIND_ITT) || (q.rkind == KIND_ENQ);
      end else begin
        msg_done = (q.rkind == KIND_PKT) && (q.ridx >= 9'h004) && (q.ridx == {1'b0, q.rlen} + 9'h004);
      end
      if (msg_done) begin
        n.ridx = 9'h000;
        n.rcrc = CRC_INIT;
      end
    end else if (q.ridx != 9'h000) begin
      n.rgap = q.rgap + 16'h0001;
      if (q.rgap == 16'(GAP - 1)) begin
        n.ridx = 9'h000;
        n.rcrc = CRC_INIT;
      end
    end
    // byte source and serialiser
    if (q.kind == KIND_ACK || q.kind == KIND_NAK) last_idx = 9'h000;
    else if (q.kind == KIND_PKT) last_idx = {1'b0, q.len} + 9'h004;
    else last_idx = 9'h001;
    if (q.tidx == 9'h000) nb = q.kind;
    else if (q.tidx == 9'h001) nb = q.tdid;
    else if (q.tidx == 9'h002) nb = q.len;
    else if (is_data) begin
      nb    = buf_out_data;
      nb_ok = buf_out_valid;
    end else if (q.tidx == {1'b0, q.len} + 9'h003) nb = q.tcrc[15:8];
    else nb = q.tcrc[7:0];
    if (tick) begin
      n.bclk = !q.bclk;
      if (q.ser_busy) begin
        n.qtr = q.qtr + 2'd1;
        if (q.qtr == 2'd3) begin
          if (q.ser_bit == 4'h8) begin
            n.ser_busy = 1'b0;
          end else begin
            n.ser_bit = q.ser_bit + 4'h1;
            n.ser_sh  = q.ser_sh >> 1;
          end
        end
      end
      if (!n.ser_busy && (q.ph == PH_TX) && !q.tlast && nb_ok) begin
        n.ser_busy    = 1'b1;
        n.ser_sh      = {nb, 1'b1};
        n.ser_bit     = 4'h0;
        n.qtr         = 2'd0;
        n.tidx        = q.tidx + 9'h001;
        n.tlast       = (q.tidx == last_idx);
        buf_out_ready = is_data;
        if (is_crc) n.tcrc = crc_step(q.tcrc, nb);
      end
    end
    // sequencer
    n.wcnt = q.wcnt + 16'h0001;
    case (q.ph)
      PH_IDLE: begin
        if (msg_done && addressed) begin
          if (mk == KIND_ITT) begin
            if (q.tx_pend) n = start_tx(n, KIND_ENQ, q.dest);
            else n = start_tx(n, KIND_ITT, q.next_id);
          end else if (mk == KIND_ENQ) begin
            n = start_tx(n, q.rx_en ? KIND_ACK : KIND_NAK, 8'h00);
          end else if ((mk == KIND_PKT) && crc_ok && q.rx_en) begin
            n              = start_tx(n, KIND_ACK, 8'h00);
            n.stat[ST_RXD] = 1'b1;
          end
        end
      end
      PH_TX: begin
        if (q.tlast && !q.ser_busy) begin
          n.wcnt = 16'h0000;
          if (q.kind == KIND_ENQ) n.ph = PH_WAIT_ENQ;
          else if (q.kind == KIND_PKT) n.ph = PH_WAIT_ACK;
          else n.ph = PH_IDLE;
        end
      end
      PH_WAIT_ENQ: begin
        if (msg_done && (mk == KIND_ACK)) n = start_tx(n, KIND_PKT, q.dest);
        else if ((msg_done && (mk == KIND_NAK)) || tmo) n = start_tx(n, KIND_ITT, q.next_id);
      end
      PH_WAIT_ACK: begin
        if ((msg_done && (mk == KIND_ACK)) || tmo) begin
          n                = start_tx(n, KIND_ITT, q.next_id);
          n.stat[ST_ACKED] = msg_done && (mk == KIND_ACK);
          n.stat[ST_TXAV]  = 1'b1;
          n.tx_pend        = 1'b0;
        end
      end
      default: n.ph = PH_IDLE;
    endcase
    n.stat[ST_ROOM] = buf_in_ready;
    n.irq_n         = !(|(n.stat & n.mask));
    // line pins
    tx_act = (n.ph == PH_TX) || n.ser_busy;
    cur    = n.ser_busy && n.ser_sh[0];
    if (backplane_mode_in) begin
      n.pa_n = !cur;
      n.pb_n = !n.bclk;
    end else begin
      n.pa_n = !(cur && (n.qtr == 2'd0));
      n.pb_n = !(cur && (n.qtr == 2'd1));
    end
    n.pa_oe = !(backplane_mode_in && pulse_a_open_drain_in) || !n.pa_n;
    n.pb_oe = 1'b1;
    n.txen  = n.pol_high ? tx_act : !tx_act;
    if (!hw_reset_n_in) begin
      n          = ST_RST;
      n.pol_high = backplane_mode_in && !line_pulse_b_n_in;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      q <= ST_RST;
    end else begin
      q <= n;
    end
  end

  assign host_data_out          = q.rdata;
  assign host_data_oe_out       = q.oe;
  assign host_irq_n_out         = q.irq_n;
  assign line_pulse_a_n_out     = q.pa_n;
  assign line_pulse_a_oe_out    = q.pa_oe;
  assign line_pulse_b_n_out     = q.pb_n;
  assign line_pulse_b_oe_out    = q.pb_oe;
  assign line_driver_enable_out = q.txen;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  a_irq_follows_mask: assert property (host_irq_n_out == !(|(q.stat & q.mask)))
    else $error("irq does not match masked status");
  a_read_needs_select: assert property (host_data_oe_out |-> $past(!chip_select_n_in))
    else $error("data driven without chip select");
  a_write_captures: assert property (req.wr && req.addr == ADDR_DEST && hw_reset_n_in |=> q.dest == $past(host_data_in))
    else $error("destination write not captured");
  a_hw_reset_clear: assert property (!hw_reset_n_in |=> q.ph == PH_IDLE && !q.ser_busy && host_irq_n_out)
    else $error("hardware reset did not clear state");
  a_dipulse_pair: assert property (!backplane_mode_in && $fell(line_pulse_a_n_out) |-> ##10 !line_pulse_b_n_out)
    else $error("second half pulse missing");
  a_od_release: assert property (hw_reset_n_in && $past(hw_reset_n_in) && $past(backplane_mode_in && pulse_a_open_drain_in)
                                  && line_pulse_a_n_out |-> !line_pulse_a_oe_out)
    else $error("open drain pin driven high");
  a_bp_clock: assert property (backplane_mode_in && hw_reset_n_in && $changed(line_pulse_b_n_out)
                                |-> ##10 ($changed(line_pulse_b_n_out) || !backplane_mode_in || !hw_reset_n_in))
    else $error("backplane clock period wrong");
  a_enq_first: assert property (q.ph == PH_TX && q.kind == KIND_PKT && $past(q.ph) != PH_TX
                                 |-> $past(q.ph) == PH_WAIT_ENQ)
    else $error("packet sent without enquiry");
  a_nak_pass: assert property (q.ph == PH_WAIT_ENQ && msg_done && mk == KIND_NAK && hw_reset_n_in
                                |=> q.ph == PH_TX && q.kind == KIND_ITT)
    else $error("token not passed after negative acknowledge");
  a_ack_delivered: assert property (q.ph == PH_WAIT_ACK && msg_done && mk == KIND_ACK && hw_reset_n_in
                                     |=> q.stat[ST_ACKED] && q.stat[ST_TXAV] && !q.tx_pend)
    else $error("delivery status not set");
  a_bad_pkt_silent: assert property (q.ph == PH_IDLE && msg_done && mk == KIND_PKT && !crc_ok |=> q.ph == PH_IDLE)
    else $error("reply sent to bad packet");
  a_enq_answer: assert property (q.ph == PH_IDLE && msg_done && mk == KIND_ENQ && addressed && hw_reset_n_in
                                  |=> q.kind == ($past(q.rx_en) ? KIND_ACK : KIND_NAK))
    else $error("wrong enquiry answer");
  a_rx_start: assert property (!q.rx_busy && line_receive_in && hw_reset_n_in |=> q.rx_busy)
    else $error("receiver missed start mark");
  a_strap_hold: assert property (hw_reset_n_in && $past(hw_reset_n_in) |-> $stable(q.pol_high))
    else $error("driver polarity changed outside reset");

  c_packet_acked: cover property (q.ph == PH_WAIT_ACK && msg_done && mk == KIND_ACK);
  c_enq_refused:  cover property (q.ph == PH_WAIT_ENQ && msg_done && mk == KIND_NAK);
  c_rx_good:      cover property (q.ph == PH_IDLE && msg_done && mk == KIND_PKT && crc_ok);
  c_buf_full:     cover property (!buf_in_ready);
endmodule

/* far_node.sv */
// Purpose: far node model on the line side of the controller
// Assumes: normal dipulse mode, 40 clock bit period
// Notes:   line idles at space between messages
`timescale 1ns/1ps
module far_node (
  input  wire logic clk_in,
  input  wire logic pulse_a_n_in,
  output logic      rx_out
);
  logic [7:0] got_q[$];
  initial rx_out = 1'b0;
  // decode: a one shows as pulse a low early in the bit
  initial begin : decode
    logic [7:0] b;
    forever begin
      @(posedge clk_in);
      if (pulse_a_n_in === 1'b0) begin
        repeat (2) @(posedge clk_in);
        for (int i = 0; i < 8; i++) begin
          repeat (40) @(posedge clk_in);
          b[i] = ~pulse_a_n_in;
        end
        repeat (30) @(posedge clk_in);
        got_q.push_back(b);
      end
    end
  end
  // send: start mark then eight bits lsb first, back to back
  task automatic send(input logic [7:0] m[$]);
    foreach (m[k]) begin
      rx_out <= 1'b1;
      repeat (40) @(posedge clk_in);
      for (int i = 0; i < 8; i++) begin
        rx_out <= m[k][i];
        repeat (40) @(posedge clk_in);
      end
    end
    rx_out <= 1'b0;
  endtask
endmodule

/* tb_top.sv */
// Purpose: self-checking bench of the node controller
// Assumes: host port in both bus modes, normal line mode, then backplane mode
// Notes:   far node answers each enquiry and packet promptly
`timescale 1ns/1ps
module tb_top;
  import node_pkg::*;
  logic        core_clk_in, sys_rst_in, hw_reset_n_in, cs_n, ds_n, wr_dir, sm, hoe, irq_n, pa_n, rx;
  logic        bp, od, pbin, txen, pa_oe, pb, pb_oe, p;
  logic [7:0]  n_tg;
  logic [2:0]  addr;
  logic [7:0]  wdata, hdo, rd, nid, did, nxt, d0, d1;
  logic [15:0] c;
  int          n_fail, checked, seed;
  token_node u_token_node (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .hw_reset_n_in(hw_reset_n_in),
    .chip_select_n_in(cs_n), .read_strobe_or_data_strobe_n_in(ds_n), .write_strobe_or_direction_in(wr_dir),
    .bus_strobe_mode_in(sm), .host_addr_in(addr), .host_data_in(wdata), .host_data_out(hdo),
    .host_data_oe_out(hoe), .host_irq_n_out(irq_n), .backplane_mode_in(bp), .pulse_a_open_drain_in(od),
    .line_pulse_a_n_out(pa_n), .line_pulse_a_oe_out(pa_oe), .line_pulse_b_n_in(pbin), .line_pulse_b_n_out(pb),
    .line_pulse_b_oe_out(pb_oe), .line_receive_in(rx), .line_driver_enable_out(txen));
  far_node u_far (.clk_in(core_clk_in), .pulse_a_n_in(pa_n), .rx_out(rx));
  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end
  task automatic test_done;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] crc(input logic [7:0] m[$]);
    logic [15:0] r;
    r = 16'h0000;
    foreach (m[k]) begin
      r ^= {8'h00, m[k]};
      repeat (8) r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    end
    return r;
  endfunction
  // one write, bus mode drawn at random
  task automatic hw(input logic sel_n, input logic [2:0] a, input logic [7:0] d);
    logic m;
    m = 1'($random(seed));
    sm <= m;
    cs_n <= sel_n;
    ds_n <= ~m;
    wr_dir <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge core_clk_in);
    cs_n <= 1'b1;
    ds_n <= 1'b1;
    wr_dir <= 1'b1;
    @(posedge core_clk_in);
  endtask
  task automatic hr(input logic [2:0] a);
    sm <= 1'($random(seed));
    cs_n <= 1'b0;
    ds_n <= 1'b0;
    wr_dir <= 1'b1;
    addr <= a;
    repeat (2) @(posedge core_clk_in);
    #1 rd = hdo;
    chk({7'h00, hoe}, 8'h01);
    @(posedge core_clk_in);
    cs_n <= 1'b1;
    ds_n <= 1'b1;
    @(posedge core_clk_in);
  endtask
  task automatic expect_msg(input logic [7:0] m[$]);
    int w;
    foreach (m[k]) begin
      w = 0;
      while (u_far.got_q.size() == 0 && w < 5000) begin
        @(posedge core_clk_in);
        w++;
      end
      if (w == 5000) begin
        n_fail++;
        $display("[FAIL] %0t no reply byte", $time);
        test_done();
      end
      chk(u_far.got_q.pop_front(), m[k]);
    end
    repeat (40) @(posedge core_clk_in);
  endtask
  initial begin
    seed = 39;
    n_fail = 0;
    checked = 0;
    {cs_n, ds_n, wr_dir, sm, addr, wdata, hw_reset_n_in, sys_rst_in} = {4'b1110, 11'h000, 2'b11};
    {bp, od, pbin} = 3'b001;
    repeat (2) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    nid = 8'h20 + ($random(seed) & 8'h1f);
    did = nid + 8'h01;
    nxt = nid + 8'h02;
    d0 = $random(seed);
    d1 = $random(seed);
    hr(ADDR_CMD);
    chk(rd & 8'h01, 8'h01);
    hw(1'b1, ADDR_MASK, 8'hff);
    hw(1'b0, ADDR_MASK, 8'h02);
    hr(ADDR_MASK);
    chk(rd, 8'h02);
    for (int t = 0; t < 2; t++) begin
      hw(1'b0, ADDR_DEST, did);
      hw(1'b0, ADDR_LEN, 8'h02);
      hw(1'b0, ADDR_NODE, nid);
      hw(1'b0, ADDR_NEXT, nxt);
      hw(1'b0, ADDR_DATA, d0);
      hw(1'b0, ADDR_DATA, d1);
      hw(1'b0, ADDR_CMD, 8'h01);
      u_far.send({KIND_ITT, nid});
      expect_msg({KIND_ENQ, did});
      u_far.send({(t == 0) ? KIND_ACK : KIND_NAK});
      c = crc({did, 8'h02, d0, d1});
      if (t == 0) expect_msg({KIND_PKT, did, 8'h02, d0, d1, c[15:8], c[7:0]});
      if (t == 0) u_far.send({KIND_ACK});
      expect_msg({KIND_ITT, nxt});
      hr(ADDR_CMD);
      chk(rd & 8'h03, (t == 0) ? 8'h03 : 8'h00);
      chk({7'h00, irq_n}, (t == 0) ? 8'h00 : 8'h01);
      hw(1'b0, ADDR_CMD, 8'h08);
    end
    hw(1'b0, ADDR_CMD, 8'h02);
    u_far.send({KIND_ENQ, nid});
    expect_msg({KIND_ACK});
    c = crc({nid, 8'h01, d1});
    u_far.send({KIND_PKT, nid, 8'h01, d1, c[15:8], c[7:0]});
    expect_msg({KIND_ACK});
    hr(ADDR_DATA);
    chk(rd, d1);
    u_far.send({KIND_PKT, nid, 8'h01, d0, ~c[15:8], c[7:0]});
    repeat (900) @(posedge core_clk_in);
    chk(8'(u_far.got_q.size()), 8'h00);
    hw(1'b0, ADDR_CMD, 8'h04);
    u_far.send({KIND_ENQ, nid});
    expect_msg({KIND_NAK});
    hw_reset_n_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    hw_reset_n_in <= 1'b1;
    @(posedge core_clk_in);
    hr(ADDR_CMD);
    chk(rd & 8'h07, 8'h01);
    chk({7'h00, txen}, 8'h01);
    chk({7'h00, pb_oe}, 8'h01);
    bp <= 1'b1;
    od <= 1'b1;
    pbin <= 1'b0;
    hw_reset_n_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    hw_reset_n_in <= 1'b1;
    pbin <= 1'b1;
    repeat (5) @(posedge core_clk_in);
    chk({6'h00, txen, pa_oe}, 8'h00);
    n_tg = 8'h00;
    p = pb;
    repeat (40) begin
      @(posedge core_clk_in);
      if (pb !== p) n_tg++;
      p = pb;
    end
    chk(n_tg, 8'h04);
    test_done();
  end
endmodule
